// *** src/i2c_addr_match_smbus_timeout.sv ***
// two-wire slave address recognition with bus timeout detection
//
// Contract
// [RULE_01] a 10-bit header starts 11110, then the two top address bits and direction
// [RULE_02] after START compare header and top bits, require write, then acknowledge
// [RULE_03] after header match compare the whole second byte with low address bits
// [RULE_04] stay selected until STOP or repeated START with another address
// [RULE_05] after repeated START a held 10-bit slave acks a read header, transmits
// [RULE_06] an unheld 10-bit slave ignores a read header after repeated START
// [RULE_07] software discards received data on the first-header-byte interrupt
// [RULE_08] the seven-bit primary address always takes part in matching; the code leaves it out while addr_ext_enable is set
// [RULE_09] extension enable appends three high bits for a 10-bit address
// [RULE_10] general call matches when its enable is set
// [RULE_11] alert response address matches when its enable is set
// [RULE_12] the second address matches when its enable is set
// [RULE_13] a nonzero range address matches by itself
// [RULE_14] range enable matches primary through range; software keeps range above primary
// [RULE_15] on any match act as slave and flag addressed after the address cycle
// [RULE_16] a 35 ms clock-low timeout releases the lines and resets the slave
// [RULE_17] after a clock-low timeout a new START is accepted at once
// [RULE_18] an active master seeing clock-low timeout requests a STOP
// [RULE_19] both lines high for the high limit flag the bus idle
// [RULE_20] data low with clock high for the limit sets a flag and the interrupt flag
// [RULE_21] software clears interrupt and clock-low flags by writing one
// [RULE_22] timeout counters count clocks and restart when the condition ends
`timescale 1ns/1ps
`include "i2c_addr_match_map.svh"

module i2c_addr_match_smbus_timeout
   import i2c_addr_match_pkg::*;
#(
   parameter int unsigned LOW_TIMEOUT_CYCLES = `LOW_TIMEOUT_CYCLES
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic sclClk,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire addrConfig_t cfg,
   input wire flagClear_t clr,
   output slaveStatus_t status
);

   localparam timeoutCount_t LOW_LIMIT = timeoutCount_t'(LOW_TIMEOUT_CYCLES);
   localparam timeoutCount_t LOW_FIRE_AT = timeoutCount_t'(LOW_TIMEOUT_CYCLES - 1);

   linkState_t link;
   linkState_t next_link;
   coreState_t core;
   coreState_t next_core;

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   // set wins over a clear landing in the same cycle
   function automatic logic flagUpdate(input logic cur, input logic set, input logic clear);
      return set | (cur & ~clear);
   endfunction

   function automatic logic sevenBitMatch(input logic [6:0] addr, input addrConfig_t c);
      logic hit;
      hit = 1'b0;
      if (!c.addr_ext_enable && addr == c.primaryAddr)
         hit = 1'b1; // [RULE_08]
      if (c.general_call_enable && addr == `GENERAL_CALL_ADDR)
         hit = 1'b1; // [RULE_10]
      if (c.alert_response_enable && addr == `ALERT_RESPONSE_ADDR)
         hit = 1'b1; // [RULE_11]
      if (c.second_addr_enable && addr == c.secondAddr)
         hit = 1'b1; // [RULE_12]
      if (c.rangeAddr != 7'h00 && addr == c.rangeAddr)
         hit = 1'b1; // [RULE_13]
      // a range programmed below the primary address matches nothing but the range address itself
      if (c.range_match_enable && addr >= c.primaryAddr && addr <= c.rangeAddr)
         hit = 1'b1; // [RULE_14]
      return hit;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // link domain: one sample and one toggle per rising clock edge

   // the clock may stop between frames; nothing here needs a later edge
   always_comb
   begin
      next_link = link;
      next_link.sampledBit = sdaIn;
      next_link.bitToggle = ~link.bitToggle;
   end

   always_ff @(posedge sclClk or negedge arst_n)
   begin
      if (!arst_n)
         link <= '0;
      else
         link <= next_link;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // module clock domain

   always_comb
   begin
      logic sclHigh;
      logic sdaHigh;
      logic startSeen;
      logic stopSeen;
      logic sclFall;
      logic bitEvent;
      logic [7:0] byteNow;
      logic [3:0] countNow;
      logic tenHit;
      logic lowFire;
      logic dataLowFire;
      logic bothHigh;
      logic dataLowClockHigh;
      logic setInterrupt;
      logic setAddressed;
      sclHigh = 1'b0;
      sdaHigh = 1'b0;
      startSeen = 1'b0;
      stopSeen = 1'b0;
      sclFall = 1'b0;
      bitEvent = 1'b0;
      byteNow = 8'h00;
      countNow = 4'h0;
      tenHit = 1'b0;
      lowFire = 1'b0;
      dataLowFire = 1'b0;
      bothHigh = 1'b0;
      dataLowClockHigh = 1'b0;
      setInterrupt = 1'b0;
      setAddressed = 1'b0;

      next_core = core;

      // pin and toggle synchronisers
      next_core.sclSync1 = sclClk;
      next_core.sclSync2 = core.sclSync1;
      next_core.sclPrev = core.sclSync2;
      next_core.sdaSync1 = sdaIn;
      next_core.sdaSync2 = core.sdaSync1;
      next_core.sdaPrev = core.sdaSync2;
      next_core.tglSync1 = link.bitToggle;
      next_core.tglSync2 = core.tglSync1;
      next_core.tglSync3 = core.tglSync2;
      next_core.tglSeen = core.tglSync3;
      next_core.bitSync1 = link.sampledBit;
      next_core.bitSync2 = core.bitSync1;
      // open drain: the data pin is only ever pulled low, never driven high
      next_core.sdaOut = 1'b0;

      sclHigh = core.sclSync2;
      sdaHigh = core.sdaSync2;
      // start and stop need the clock high on two samples, so a clock edge is never one
      startSeen = sclHigh && core.sclPrev && core.sdaPrev && !sdaHigh;
      stopSeen = sclHigh && core.sclPrev && !core.sdaPrev && sdaHigh;
      sclFall = core.sclPrev && !sclHigh;
      // acting one stage after the toggle lands gives the data bit a settled cycle
      bitEvent = core.tglSync3 != core.tglSeen;
      byteNow = {core.shiftByte[6:0], core.bitSync2};
      countNow = core.bitCount + 4'h1;
      bothHigh = sclHigh && sdaHigh;
      dataLowClockHigh = sclHigh && !sdaHigh;

      // timeout counters
      // each parks at its limit, so one long episode fires its flag only once
      if (!sclHigh)
      begin
         if (core.lowCount != LOW_LIMIT)
            next_core.lowCount = core.lowCount + timeoutCount_t'(1); // [RULE_22]
      end
      else
         next_core.lowCount = '0; // [RULE_22]
      lowFire = !sclHigh && core.lowCount == LOW_FIRE_AT; // [RULE_16]

      if (bothHigh)
      begin
         if (core.highCount != cfg.highTimeoutLimit)
            next_core.highCount = core.highCount + highCount_t'(1); // [RULE_22]
      end
      else
         next_core.highCount = '0; // [RULE_22]
      // level flag: drops by itself as soon as either line goes low
      next_core.status.high_timeout_idle_flag =
         bothHigh && core.highCount == cfg.highTimeoutLimit; // [RULE_19]

      if (dataLowClockHigh)
      begin
         if (core.dataLowCount != cfg.highTimeoutLimit)
            next_core.dataLowCount = core.dataLowCount + highCount_t'(1); // [RULE_22]
      end
      else
         next_core.dataLowCount = '0; // [RULE_22]
      dataLowFire = cfg.moduleEnable && dataLowClockHigh && cfg.highTimeoutLimit != '0 &&
         core.dataLowCount == cfg.highTimeoutLimit - highCount_t'(1); // [RULE_20]

      // acknowledge drive, changed only while the clock is low
      // releasing on the fall after the ninth clock keeps the ack still while sampled
      if (sclFall && core.ackPending)
      begin
         next_core.sdaOe = 1'b1;
         next_core.ackPending = 1'b0;
      end
      else if (sclFall && core.releaseArm)
      begin
         next_core.sdaOe = 1'b0;
         next_core.releaseArm = 1'b0;
      end

      // address byte handling
      if (bitEvent)
      begin
         case (core.state)
            ST_ADDR_BYTE:
            begin
               next_core.shiftByte = byteNow;
               next_core.bitCount = countNow;
               if (countNow == `BITS_PER_BYTE)
               begin
                  tenHit = cfg.addr_ext_enable && byteNow[7:3] == `TENBIT_PREFIX &&
                     byteNow[2:1] == cfg.extAddr[2:1]; // [RULE_01] [RULE_02] [RULE_09]
                  next_core.state = ST_ACK_SLOT;
                  next_core.ackPending = 1'b1;
                  if (tenHit && byteNow[0] == `DIR_WRITE)
                  begin
                     next_core.afterAck = ST_LOW_ADDR; // [RULE_02]
                     next_core.markAddressed = 1'b0;
                     next_core.becomeTransmitter = 1'b0;
                     next_core.tenBitHeld = 1'b0;
                     // data held at this interrupt is not valid payload
                     setInterrupt = 1'b1; // [RULE_07]
                  end
                  else if (tenHit && core.tenBitHeld)
                  begin
                     next_core.afterAck = ST_SELECTED; // [RULE_05]
                     next_core.markAddressed = 1'b1;
                     next_core.becomeTransmitter = 1'b1; // [RULE_05]
                  end
                  else if (!tenHit && sevenBitMatch(byteNow[7:1], cfg))
                  begin
                     next_core.afterAck = ST_SELECTED;
                     next_core.markAddressed = 1'b1;
                     next_core.becomeTransmitter = byteNow[0];
                     next_core.tenBitHeld = 1'b0;
                  end
                  else
                  begin
                     // also covers a read header for a slave never addressed before
                     next_core.state = ST_IGNORE; // [RULE_06]
                     next_core.ackPending = 1'b0;
                     next_core.tenBitHeld = 1'b0;
                     next_core.status.selected = 1'b0; // [RULE_04]
                     next_core.status.slaveTransmit = 1'b0;
                  end
               end
            end
            ST_LOW_ADDR:
            begin
               next_core.shiftByte = byteNow;
               next_core.bitCount = countNow;
               if (countNow == `BITS_PER_BYTE)
               begin
                  if (byteNow == {cfg.extAddr[0], cfg.primaryAddr}) // [RULE_03]
                  begin
                     next_core.state = ST_ACK_SLOT;
                     next_core.ackPending = 1'b1;
                     next_core.afterAck = ST_SELECTED;
                     next_core.markAddressed = 1'b1;
                     next_core.becomeTransmitter = 1'b0;
                     next_core.tenBitHeld = 1'b1; // [RULE_05]
                  end
                  else
                  begin
                     next_core.state = ST_IGNORE; // [RULE_03]
                     next_core.status.selected = 1'b0;
                     next_core.status.slaveTransmit = 1'b0;
                  end
               end
            end
            ST_ACK_SLOT:
            begin
               next_core.bitCount = 4'h0;
               next_core.releaseArm = 1'b1;
               next_core.state = core.afterAck;
               if (core.markAddressed)
               begin
                  setAddressed = 1'b1; // [RULE_15]
                  next_core.status.selected = 1'b1; // [RULE_04]
                  next_core.status.slaveTransmit = core.becomeTransmitter;
               end
            end
            default:
            begin
            end
         endcase
      end

      // bus conditions override byte handling
      if (!cfg.moduleEnable || lowFire)
      begin
         next_core.state = ST_IDLE; // [RULE_17]
         next_core.sdaOe = 1'b0; // [RULE_16]
         next_core.ackPending = 1'b0;
         next_core.releaseArm = 1'b0;
         next_core.tenBitHeld = 1'b0;
         next_core.bitCount = 4'h0;
         next_core.status.selected = 1'b0;
         next_core.status.slaveTransmit = 1'b0;
      end
      else if (stopSeen)
      begin
         next_core.state = ST_IDLE; // [RULE_04]
         next_core.sdaOe = 1'b0;
         next_core.ackPending = 1'b0;
         next_core.releaseArm = 1'b0;
         next_core.tenBitHeld = 1'b0;
         next_core.status.selected = 1'b0; // [RULE_04]
         next_core.status.slaveTransmit = 1'b0;
         next_core.status.busBusy = 1'b0;
      end
      else if (startSeen)
      begin
         // selection survives until the new address says otherwise
         next_core.state = ST_ADDR_BYTE; // [RULE_04]
         next_core.bitCount = 4'h0;
         next_core.sdaOe = 1'b0;
         next_core.ackPending = 1'b0;
         next_core.releaseArm = 1'b0;
         next_core.status.busBusy = 1'b1;
      end

      next_core.status.masterStopRequest =
         cfg.masterActive && (core.status.masterStopRequest || lowFire); // [RULE_18]

      // a disabled module watches the bus only for clock-low timeout: busy, idle and stop request are held off,
      // and the high counters restart so no stale run fires once it is enabled
      if (!cfg.moduleEnable)
      begin
         next_core.status.busBusy = 1'b0;
         next_core.status.high_timeout_idle_flag = 1'b0;
         next_core.status.masterStopRequest = 1'b0;
         next_core.highCount = '0;
         next_core.dataLowCount = '0;
      end

      next_core.status.addressed_as_slave_flag = flagUpdate(
         core.status.addressed_as_slave_flag, setAddressed, clr.clearAddressed); // [RULE_15]
      next_core.status.clock_low_timeout_flag = flagUpdate(
         core.status.clock_low_timeout_flag, lowFire, clr.clearLowTimeout); // [RULE_16]
      next_core.status.data_low_clock_high_timeout_flag = flagUpdate(
         core.status.data_low_clock_high_timeout_flag, dataLowFire,
         clr.clearDataLowTimeout); // [RULE_20]
      next_core.status.module_interrupt_flag = flagUpdate(
         core.status.module_interrupt_flag, setInterrupt | setAddressed | dataLowFire,
         clr.clearInterrupt); // [RULE_20]
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         core <= '0;
      else
         core <= next_core;
   end

   assign sdaOut = core.sdaOut;
   assign sdaOe = core.sdaOe;
   assign status = core.status;

endmodule // i2c_addr_match_smbus_timeout

// *** shared/i2c_addr_match_map.svh ***
// constants for the slave address matcher and the bus timeout detectors
`ifndef I2C_ADDR_MATCH_MAP_SVH
`define I2C_ADDR_MATCH_MAP_SVH

// first five bits of a 10-bit address header (11110)
`define TENBIT_PREFIX 5'h1E
`define GENERAL_CALL_ADDR 7'h00
`define ALERT_RESPONSE_ADDR 7'h0C
`define DIR_WRITE 1'h0
`define DIR_READ 1'h1
`define BITS_PER_BYTE 4'h8

`define CLK_PERIOD_NS 4
`define LOW_TIMEOUT_MS 35
`define LOW_TIMEOUT_CYCLES ((`LOW_TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)
`define TIMEOUT_COUNT_WIDTH 24
`define HIGH_LIMIT_WIDTH 16

`endif

// *** shared/i2c_addr_match_pkg.sv ***
// types shared by the slave address matcher and its bench
package i2c_addr_match_pkg;
`include "i2c_addr_match_map.svh"

   typedef logic [`TIMEOUT_COUNT_WIDTH-1:0] timeoutCount_t;
   typedef logic [`HIGH_LIMIT_WIDTH-1:0] highCount_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR_BYTE,
      ST_ACK_SLOT,
      ST_LOW_ADDR,
      ST_SELECTED,
      ST_IGNORE
   } slaveState_t;

   typedef struct packed {
      logic moduleEnable;
      logic [6:0] primaryAddr;
      logic [2:0] extAddr;
      logic addr_ext_enable;
      logic general_call_enable;
      logic alert_response_enable;
      logic second_addr_enable;
      logic [6:0] secondAddr;
      logic [6:0] rangeAddr;
      logic range_match_enable;
      highCount_t highTimeoutLimit;
      logic masterActive;
   } addrConfig_t;

   typedef struct packed {
      logic clearAddressed;
      logic clearLowTimeout;
      logic clearDataLowTimeout;
      logic clearInterrupt;
   } flagClear_t;

   typedef struct packed {
      logic addressed_as_slave_flag;
      logic clock_low_timeout_flag;
      logic high_timeout_idle_flag;
      logic data_low_clock_high_timeout_flag;
      logic module_interrupt_flag;
      logic busBusy;
      logic selected;
      logic slaveTransmit;
      logic masterStopRequest;
   } slaveStatus_t;

   typedef struct packed {
      logic bitToggle;
      logic sampledBit;
   } linkState_t;

   typedef struct packed {
      logic sclSync1;
      logic sclSync2;
      logic sclPrev;
      logic sdaSync1;
      logic sdaSync2;
      logic sdaPrev;
      logic tglSync1;
      logic tglSync2;
      logic tglSync3;
      logic tglSeen;
      logic bitSync1;
      logic bitSync2;
      slaveState_t state;
      slaveState_t afterAck;
      logic markAddressed;
      logic becomeTransmitter;
      logic tenBitHeld;
      logic [7:0] shiftByte;
      logic [3:0] bitCount;
      logic ackPending;
      logic releaseArm;
      logic sdaOut;
      logic sdaOe;
      timeoutCount_t lowCount;
      highCount_t highCount;
      highCount_t dataLowCount;
      slaveStatus_t status;
   } coreState_t;

endpackage

// *** tb/i2c_addr_match_smbus_timeout_props.sv ***
// concurrent checks for the address matcher and timeout detectors
`timescale 1ns/1ps
module i2c_addr_match_smbus_timeout_props
   import i2c_addr_match_pkg::*;
#(
   parameter int unsigned LOW_TIMEOUT_CYCLES = 200
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic sclClk,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire addrConfig_t cfg,
   input wire flagClear_t clr,
   input wire slaveStatus_t status
);
   // raw run lengths; the design sees lines late, so these never run short
   int unsigned lowRun;
   int unsigned highRun;
   int unsigned dlowRun;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lowRun <= 0;
         highRun <= 0;
         dlowRun <= 0;
      end
      else
      begin
         lowRun <= sclClk ? 0 : lowRun + 1;
         highRun <= (sclClk && sdaIn) ? highRun + 1 : 0;
         dlowRun <= (sclClk && !sdaIn) ? dlowRun + 1 : 0;
      end
   end
   ////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   drive_low_a: assert property (sdaOe |-> !sdaOut)
      else $error("data line driven high");
   ack_stands_a: assert property ($rose(sdaOe) |-> !sclClk ##1 sdaOe [*8])
      else $error("ack not held while clock low");
   low_release_a: assert property ($rose(status.clock_low_timeout_flag)
      |-> ##[0:2] (!sdaOe && !status.selected))
      else $error("lines not released on clock low timeout");
   low_count_a: assert property ($rose(status.clock_low_timeout_flag)
      |-> lowRun >= LOW_TIMEOUT_CYCLES)
      else $error("clock low timeout too early");
   low_late_a: assert property (lowRun == LOW_TIMEOUT_CYCLES + 8
      |-> status.clock_low_timeout_flag)
      else $error("clock low timeout missed");
   low_sticky_a: assert property (status.clock_low_timeout_flag && !clr.clearLowTimeout
      |=> status.clock_low_timeout_flag)
      else $error("timeout flag dropped without clear");
   stop_req_a: assert property ($rose(status.masterStopRequest)
      |-> cfg.masterActive && lowRun >= LOW_TIMEOUT_CYCLES)
      else $error("stop request without master timeout");
   idle_count_a: assert property ($rose(status.high_timeout_idle_flag)
      |-> highRun >= cfg.highTimeoutLimit)
      else $error("idle flag too early");
   idle_drop_a: assert property (!sdaIn [*5] |-> !status.high_timeout_idle_flag)
      else $error("idle flag with data low");
   dlow_count_a: assert property ($rose(status.data_low_clock_high_timeout_flag)
      |-> cfg.highTimeoutLimit != 0 && dlowRun >= cfg.highTimeoutLimit)
      else $error("data low flag too early");
   dlow_irq_a: assert property ($rose(status.data_low_clock_high_timeout_flag)
      |-> ##[0:1] status.module_interrupt_flag)
      else $error("data low flag without interrupt");
   addr_irq_a: assert property ($rose(status.addressed_as_slave_flag)
      |-> ##[0:1] status.module_interrupt_flag)
      else $error("addressed without interrupt");
endmodule // i2c_addr_match_smbus_timeout_props

bind i2c_addr_match_smbus_timeout i2c_addr_match_smbus_timeout_props
   #(.LOW_TIMEOUT_CYCLES(LOW_TIMEOUT_CYCLES)) u_props (.clk(clk), .arst_n(arst_n),
   .sclClk(sclClk), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .cfg(cfg),
   .clr(clr), .status(status));

// *** tb/i2c_bus_master_model.sv ***
// behavioural bus master driving the clock and data lines
`timescale 1ns/1ps
module i2c_bus_master_model
(
   output logic sclClk,
   output logic sdaDrive,
   input wire logic sdaWire
);
   // clock stands high between frames
   initial
   begin
      sclClk = 1'h1;
      sdaDrive = 1'h1;
   end
   // odd offset keeps bus edges off the module clock edges until the bench next waits on the clock
   task automatic startCond();
      #0.7 sdaDrive = 1'h1;
      #30 sclClk = 1'h1;
      #40 sdaDrive = 1'h0;
      #40 sclClk = 1'h0;
   endtask
   // data moves 10 ns after the clock falls so no false start or stop is seen
   task automatic sendByte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--)
      begin
         #10 sdaDrive = b[i];
         #30 sclClk = 1'h1;
         #40 sclClk = 1'h0;
      end
      #10 sdaDrive = 1'h1;
      #30 sclClk = 1'h1;
      ack = !sdaWire;
      #40 sclClk = 1'h0;
   endtask
   task automatic stopCond();
      #10 sdaDrive = 1'h0;
      #30 sclClk = 1'h1;
      #40 sdaDrive = 1'h1;
      #40;
   endtask
   task automatic stuckData(input int t);
      #0.7 sdaDrive = 1'h0;
      #t sdaDrive = 1'h1;
   endtask
endmodule // i2c_bus_master_model

// *** tb/i2c_addr_match_smbus_timeout_tb_top.sv ***
// self-checking bench for the address matcher and timeout detectors
`timescale 1ns/1ps
`include "i2c_addr_match_map.svh"
module i2c_addr_match_smbus_timeout_tb_top;
   import i2c_addr_match_pkg::*;
   localparam int unsigned LOW_CYC = 200;
   logic clk;
   logic arst_n;
   logic sclClk;
   logic sdaDrive;
   logic sdaIn;
   logic sdaOut;
   logic sdaOe;
   addrConfig_t cfg;
   flagClear_t clr;
   slaveStatus_t status;
   int miscompares;
   int cmp_count;
   int seed = 32'h8e14_b04f;
   logic [31:0] r;
   logic [6:0] a;
   logic [6:0] hdr;
   logic ack;
   logic bad;
   // open-drain data line with pull-up
   assign sdaIn = sdaDrive & ~(sdaOe & ~sdaOut);
   i2c_bus_master_model u_bus (.sclClk(sclClk), .sdaDrive(sdaDrive), .sdaWire(sdaIn));
   i2c_addr_match_smbus_timeout #(.LOW_TIMEOUT_CYCLES(LOW_CYC)) u_dut (.clk(clk),
      .arst_n(arst_n), .sclClk(sclClk), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .cfg(cfg), .clr(clr), .status(status));
   initial
   begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   ////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic settle();
      repeat (8) @(negedge clk);
   endtask
   task automatic clearAll();
      @(negedge clk);
      clr = 4'hF;
      @(negedge clk);
      clr = 4'h0;
   endtask
   function automatic logic expMatch(input logic [6:0] x);
      return (!cfg.addr_ext_enable && x == cfg.primaryAddr)
         || (cfg.general_call_enable && x == `GENERAL_CALL_ADDR)
         || (cfg.alert_response_enable && x == `ALERT_RESPONSE_ADDR)
         || (cfg.second_addr_enable && x == cfg.secondAddr)
         || (cfg.rangeAddr != 7'h00 && x == cfg.rangeAddr)
         || (cfg.range_match_enable && x >= cfg.primaryAddr && x <= cfg.rangeAddr);
   endfunction
   task automatic addr7(input logic [6:0] x, input logic rw, input logic exp);
      u_bus.startCond();
      u_bus.sendByte({x, rw}, ack);
      settle();
      chk(ack, exp);
      chk({status.selected, status.addressed_as_slave_flag}, {exp, exp});
      chk(status.busBusy, 1'h1);
      if (exp)
         chk(status.slaveTransmit, rw);
      u_bus.stopCond();
      settle();
      chk(status.selected, 1'h0);
      chk(status.busBusy, 1'h0);
      clearAll();
   endtask
   ////////////////////////////////////////
   initial
   begin
      arst_n = 1'h0;
      cfg = '0;
      clr = '0;
      miscompares = 0;
      cmp_count = 0;
      repeat (4) @(negedge clk);
      arst_n = 1'h1;
      chk({sdaOe, status}, 16'h0000);
      repeat (4) @(negedge clk);
      cfg.moduleEnable = 1'h1;
      cfg.highTimeoutLimit = 16'h0032;
      for (int n = 0; n < 24; n++)
      begin
         r = $random(seed);
         cfg.primaryAddr = {1'h0, r[5:0]} + 7'h08;
         cfg.rangeAddr = r[24] ? cfg.primaryAddr + {4'h0, r[9:7]} + 7'h01 : 7'h00;
         cfg.secondAddr = r[16:10];
         {cfg.general_call_enable, cfg.alert_response_enable, cfg.second_addr_enable,
            cfg.range_match_enable} = r[20:17];
         cfg.range_match_enable &= r[24];
         case (r[23:21])
            3'h0: a = cfg.primaryAddr;
            3'h1: a = `GENERAL_CALL_ADDR;
            3'h2: a = `ALERT_RESPONSE_ADDR;
            3'h3: a = cfg.secondAddr;
            3'h4: a = cfg.rangeAddr;
            3'h5: a = cfg.primaryAddr + 7'h01;
            default: a = r[31:25];
         endcase
         addr7(a, r[6], expMatch(a));
      end
      $display("test done: seven-bit sources");
      cfg.addr_ext_enable = 1'h1;
      cfg.rangeAddr = 7'h00;
      {cfg.general_call_enable, cfg.alert_response_enable, cfg.second_addr_enable,
         cfg.range_match_enable} = 4'h0;
      for (int n = 0; n < 3; n++)
      begin
         r = $random(seed);
         bad = n[0];
         cfg.extAddr = r[2:0];
         cfg.primaryAddr = {1'h0, r[8:3]};
         hdr = {`TENBIT_PREFIX, cfg.extAddr[2:1]};
         addr7(cfg.primaryAddr, 1'h0, 1'h0);
         u_bus.startCond();
         u_bus.sendByte({hdr, `DIR_READ}, ack);
         chk(ack, 1'h0);
         u_bus.startCond();
         u_bus.sendByte({hdr, `DIR_WRITE}, ack);
         settle();
         chk({ack, status.addressed_as_slave_flag}, 2'h2);
         chk(status.module_interrupt_flag, 1'h1);
         u_bus.sendByte({cfg.extAddr[0], cfg.primaryAddr ^ {6'h00, bad}}, ack);
         settle();
         chk({ack, status.selected}, {!bad, !bad});
         u_bus.startCond();
         u_bus.sendByte({hdr, `DIR_READ}, ack);
         settle();
         chk({ack, status.slaveTransmit}, {!bad, !bad});
         // a repeated start to another device's header drops the selection
         u_bus.startCond();
         u_bus.sendByte({hdr ^ 7'h01, `DIR_WRITE}, ack);
         settle();
         chk({ack, status.selected}, 2'h0);
         u_bus.stopCond();
         clearAll();
      end
      $display("test done: ten-bit addressing");
      cfg.addr_ext_enable = 1'h0;
      cfg.masterActive = 1'h1;
      u_bus.startCond();
      u_bus.sendByte({cfg.primaryAddr, `DIR_WRITE}, ack);
      // clock left low after the ack clock, well past the limit
      #(LOW_CYC * 4 + 400);
      chk(status.clock_low_timeout_flag, 1'h1);
      chk({status.selected, sdaOe}, 2'h0);
      chk(status.masterStopRequest, 1'h1);
      @(negedge clk);
      cfg.masterActive = 1'h0;
      settle();
      chk(status.masterStopRequest, 1'h0);
      u_bus.stopCond();
      clearAll();
      chk(status.clock_low_timeout_flag, 1'h0);
      addr7(cfg.primaryAddr, 1'h1, 1'h1);
      $display("test done: clock low timeout");
      repeat (80) @(negedge clk);
      chk(status.high_timeout_idle_flag, 1'h1);
      u_bus.stuckData(400);
      settle();
      chk(status.high_timeout_idle_flag, 1'h0);
      chk(status.data_low_clock_high_timeout_flag, 1'h1);
      chk(status.module_interrupt_flag, 1'h1);
      clearAll();
      chk(status.data_low_clock_high_timeout_flag, 1'h0);
      $display("test done: high timeouts");
      print_verdict();
   end
   // whole run is near 50 us
   initial
   begin
      #200000;
      miscompares++;
      print_verdict();
   end
endmodule // i2c_addr_match_smbus_timeout_tb_top
